/* nand_ecc_consts.svh */
// Offsets, field positions, sector geometry and reset values of the sector result register block
`ifndef NAND_ECC_CONSTS_SVH
`define NAND_ECC_CONSTS_SVH

// Register byte offsets
`define OFF_SECTOR3_RESULT   8'h00
`define OFF_SECTOR4_RESULT   8'h04
`define OFF_SECTOR5_RESULT   8'h08
`define OFF_SECTOR6_RESULT   8'h0C
`define OFF_SECTOR7_RESULT   8'h10
`define OFF_SECTOR8_RESULT   8'h14
`define OFF_SECTOR9_RESULT   8'h18
`define OFF_ECC_CTRL         8'h20
`define OFF_ECC_EXPECT       8'h24
`define OFF_ECC_STATUS       8'h28
`define OFF_ECC_MASK         8'h2C

// Result register field positions
`define FLD_BIT_LSB          0
`define FLD_BIT_MSB          2
`define FLD_WORD_LSB         3
`define FLD_WORD_MSB         10
`define FLD_CHECK_LSB        12
`define FLD_CHECK_MSB        22

// Control, expect and status field positions
`define FLD_CTRL_ENABLE      0
`define FLD_CTRL_CLEAR       1
`define FLD_EXP_SEL_LSB      16
`define FLD_EXP_SEL_MSB      19
`define FLD_ST_PAGE_DONE     0
`define FLD_ST_ERR_FOUND     1

// Sector geometry
`define SECTOR_FIRST         4'h3
`define SECTOR_LAST          4'h9
`define SECTOR_LAST_BYTE     12'h9FF

// Reset values
`define RST_CTRL             1'h1
`define RST_STATUS           2'h0
`define RST_MASK             2'h0
`define RST_CHECK            11'h000

`endif

/* nand_ecc_pkg.sv */
// Types shared by the sector result register block
package nand_ecc_pkg;
	typedef logic [10:0] check_t;
	typedef logic [1:0]  resp_t;
	typedef logic [1:0]  event_t;
	localparam resp_t RESP_OKAY   = 2'h0;
	localparam resp_t RESP_SLVERR = 2'h2;
endpackage

/* sector_ecc_unit.sv */
// One 256-byte sector: check value accumulator and single bit error locator
`timescale 1ns/100ps
`include "nand_ecc_consts.svh"
module sector_ecc_unit import nand_ecc_pkg::*; #(
	parameter logic [3:0] SECTOR = 4'h3
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clear,
	input  wire logic        byte_valid,
	input  wire logic [11:0] byte_addr,
	input  wire logic [7:0]  byte_data,
	input  wire logic        load_expect,
	input  wire check_t      expect_value,
	output check_t           check_q,
	output check_t           location_q
);

	logic   in_sector;
	check_t check_d;

	// Each set data bit contributes its own {word, bit} position
	function automatic check_t byte_parity(input logic [7:0] waddr, input logic [7:0] data);
		check_t acc;
		acc = `RST_CHECK;
		for (int b = 0; b < 8; b++) begin
			if (data[b]) begin
				acc = acc ^ {waddr, 3'(b)};
			end
		end
		return acc;
	endfunction

	assign in_sector = byte_valid && (byte_addr[11:8] == SECTOR);
	assign check_d   = check_q ^ byte_parity(byte_addr[7:0], byte_data);

	// Check value accumulates over the sector's 256 bytes only
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			check_q <= `RST_CHECK;
		end else if (in_sector) begin
			check_q <= check_d;
		end
	end

	// A single flipped bit makes the difference equal to its own position;
	// a flip of bit 0 of word 0 cannot be told from no error at all
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			location_q <= `RST_CHECK;
		end else if (load_expect) begin
			location_q <= check_q ^ expect_value;
		end
	end

	property p_outside_sector;
		@(posedge aclk) disable iff (!aresetn)
		(!clear && !(byte_valid && byte_addr[11:8] == SECTOR)) |=> $stable(check_q);
	endproperty
	a_outside_sector: assert property (p_outside_sector) else $error("check changed by foreign byte");

	property p_bit_offset;
		@(posedge aclk) disable iff (!aresetn)
		(load_expect && !clear) |=> location_q[2:0] == ($past(check_q[2:0]) ^ $past(expect_value[2:0]));
	endproperty
	a_bit_offset: assert property (p_bit_offset) else $error("bit offset wrong");

	sequence s_word_flip;
		!clear && in_sector && (byte_data == 8'h01) ##1 !clear && load_expect && (expect_value == $past(check_q));
	endsequence
	property p_word_location;
		@(posedge aclk) disable iff (!aresetn)
		s_word_flip |=> location_q[10:3] == $past(byte_addr[7:0], 2);
	endproperty
	a_word_location: assert property (p_word_location) else $error("word location wrong");

endmodule

/* nand_sector_ecc_result_regs.sv */
// Sector three to nine ECC result registers with AXI4-Lite slave and interrupt
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "nand_ecc_consts.svh"
module nand_sector_ecc_result_regs import nand_ecc_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        page_start,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	output logic             irq
);

	// Bus state
	logic        aw_have_q;
	logic [7:0]  aw_addr_q;
	logic        w_have_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	resp_t       bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	resp_t       rresp_q;
	logic        do_write;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_value;

	// Block state
	logic        ctrl_enable_q;
	logic        clear_pulse;
	event_t      status_q;
	event_t      mask_q;
	event_t      event_set;
	logic [11:0] byte_addr_q;
	logic        byte_take;
	logic        load_expect;
	logic [3:0]  expect_sel;
	check_t      expect_value;
	check_t      check_w [`SECTOR_FIRST:`SECTOR_LAST];
	check_t      loc_w   [`SECTOR_FIRST:`SECTOR_LAST];
	logic        loc_nonzero;

	// Handshake outputs come straight from the holding flags
	assign awready = !aw_have_q && !bvalid_q;
	assign wready  = !w_have_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;

	// Address and data are captured independently so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	// Result registers are read-only, so writing one earns an error response
	always_comb begin
		unique case (aw_addr_q)
			`OFF_ECC_CTRL, `OFF_ECC_EXPECT, `OFF_ECC_STATUS, `OFF_ECC_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Control: enable gates accumulation, clear is a self-clearing strobe
	assign clear_pulse = page_start ||
		(do_write && aw_addr_q == `OFF_ECC_CTRL && w_strb_q[0] && w_data_q[`FLD_CTRL_CLEAR]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_enable_q <= `RST_CTRL;
		end else if (do_write && aw_addr_q == `OFF_ECC_CTRL && w_strb_q[0]) begin
			ctrl_enable_q <= w_data_q[`FLD_CTRL_ENABLE];
		end
	end

	// Byte counter over the page; the sector is its upper nibble
	assign byte_take = byte_valid && ctrl_enable_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || page_start) begin
			byte_addr_q <= 12'h000;
		end else if (byte_take) begin
			byte_addr_q <= 12'(byte_addr_q + 12'h001);
		end
	end

	// Software hands back the stored check value of one sector to locate errors
	assign load_expect  = do_write && aw_addr_q == `OFF_ECC_EXPECT && w_strb_q[0];
	assign expect_sel   = w_data_q[`FLD_EXP_SEL_MSB:`FLD_EXP_SEL_LSB];
	assign expect_value = w_data_q[10:0];

	genvar g;
	generate
		for (g = `SECTOR_FIRST; g <= `SECTOR_LAST; g++) begin : g_sector
			sector_ecc_unit #(
				.SECTOR       (4'(g))
			) u_unit (
				.aclk         (aclk),
				.aresetn      (aresetn),
				.clear        (clear_pulse),
				.byte_valid   (byte_take),
				.byte_addr    (byte_addr_q),
				.byte_data    (byte_data),
				.load_expect  (load_expect && expect_sel == 4'(g)),
				.expect_value (expect_value),
				.check_q      (check_w[g]),
				.location_q   (loc_w[g])
			);
		end
	endgenerate

	// Events: last byte of the page, and a nonzero location after a compare
	assign loc_nonzero = (expect_sel >= `SECTOR_FIRST) && (expect_sel <= `SECTOR_LAST) &&
		((check_w[expect_sel] ^ expect_value) != `RST_CHECK);
	assign event_set[`FLD_ST_PAGE_DONE] = byte_take && byte_addr_q == `SECTOR_LAST_BYTE;
	assign event_set[`FLD_ST_ERR_FOUND] = load_expect && loc_nonzero;

	// Sticky status, write one to clear; a set in the same cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= `RST_STATUS;
		end else if (do_write && aw_addr_q == `OFF_ECC_STATUS && w_strb_q[0]) begin
			status_q <= (status_q & ~w_data_q[1:0]) | event_set;
		end else begin
			status_q <= status_q | event_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= `RST_MASK;
		end else if (do_write && aw_addr_q == `OFF_ECC_MASK && w_strb_q[0]) begin
			mask_q <= w_data_q[1:0];
		end
	end

	assign irq = |(status_q & mask_q);

	// Result word: reserved and zero bits are packed as constant zeros
	function automatic logic [31:0] pack_result(input check_t chk, input check_t loc);
		return {8'h00, 1'b0, chk, 1'b0, loc};
	endfunction

	// Read decode; each result offset is tied to its own sector
	always_comb begin
		rd_hit   = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (araddr)
			`OFF_SECTOR3_RESULT: rd_value = pack_result(check_w[3], loc_w[3]);
			`OFF_SECTOR4_RESULT: rd_value = pack_result(check_w[4], loc_w[4]);
			`OFF_SECTOR5_RESULT: rd_value = pack_result(check_w[5], loc_w[5]);
			`OFF_SECTOR6_RESULT: rd_value = pack_result(check_w[6], loc_w[6]);
			`OFF_SECTOR7_RESULT: rd_value = pack_result(check_w[7], loc_w[7]);
			`OFF_SECTOR8_RESULT: rd_value = pack_result(check_w[8], loc_w[8]);
			`OFF_SECTOR9_RESULT: rd_value = pack_result(check_w[9], loc_w[9]);
			`OFF_ECC_CTRL:       rd_value = {31'h0000_0000, ctrl_enable_q};
			`OFF_ECC_STATUS:     rd_value = {30'h0000_0000, status_q};
			`OFF_ECC_MASK:       rd_value = {30'h0000_0000, mask_q};
			`OFF_ECC_EXPECT:     rd_value = 32'h0000_0000;
			default:             rd_hit   = 1'b0;
		endcase
	end

	// Read data is registered: one cycle from address to answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_value;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	sequence s_read_at(logic [7:0] off);
		arvalid && arready && araddr == off;
	endsequence

	property p_layout;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && araddr <= `OFF_SECTOR9_RESULT) |=> rdata[31:23] == 9'h000 && rdata[11] == 1'b0;
	endproperty
	a_layout: assert property (p_layout) else $error("reserved result bits not zero");

	property p_sector3;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR3_RESULT) |=> rdata[22:12] == $past(check_w[3]) && rdata[10:0] == $past(loc_w[3]);
	endproperty
	a_sector3: assert property (p_sector3) else $error("sector 3 result mismatch");

	property p_sector4;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR4_RESULT) |=> rdata[22:12] == $past(check_w[4]) && rdata[10:0] == $past(loc_w[4]);
	endproperty
	a_sector4: assert property (p_sector4) else $error("sector 4 result mismatch");

	property p_sector5;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR5_RESULT) |=> rdata[22:12] == $past(check_w[5]) && rdata[10:0] == $past(loc_w[5]);
	endproperty
	a_sector5: assert property (p_sector5) else $error("sector 5 result mismatch");

	property p_sector6;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR6_RESULT) |=> rdata[22:12] == $past(check_w[6]) && rdata[10:0] == $past(loc_w[6]);
	endproperty
	a_sector6: assert property (p_sector6) else $error("sector 6 result mismatch");

	property p_sector7;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR7_RESULT) |=> rdata[22:12] == $past(check_w[7]) && rdata[10:0] == $past(loc_w[7]);
	endproperty
	a_sector7: assert property (p_sector7) else $error("sector 7 result mismatch");

	property p_sector8;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR8_RESULT) |=> rdata[22:12] == $past(check_w[8]) && rdata[10:0] == $past(loc_w[8]);
	endproperty
	a_sector8: assert property (p_sector8) else $error("sector 8 result mismatch");

	property p_sector9;
		@(posedge aclk) disable iff (!aresetn)
		s_read_at(`OFF_SECTOR9_RESULT) |=> rdata[22:12] == $past(check_w[9]) && rdata[10:0] == $past(loc_w[9]);
	endproperty
	a_sector9: assert property (p_sector9) else $error("sector 9 result mismatch");

	property p_sector_bytes;
		@(posedge aclk) disable iff (!aresetn)
		(byte_take && !page_start && byte_addr_q < 12'h300) |=> $stable(check_w[3]);
	endproperty
	a_sector_bytes: assert property (p_sector_bytes) else $error("sector 3 moved by earlier byte");

	property p_locate;
		@(posedge aclk) disable iff (!aresetn)
		(load_expect && !page_start && expect_sel == 4'h3) |=> loc_w[3] == ($past(check_w[3]) ^ $past(expect_value));
	endproperty
	a_locate: assert property (p_locate) else $error("sector 3 location wrong");

	// Bus answers and event bookkeeping; a lost event would hide a page or an error from software
	property p_write_answer;
		@(posedge aclk) disable iff (!aresetn)
		do_write |=> bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write response missing");

	property p_read_answer;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready) |=> rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer missing");

	property p_reserved_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && aw_addr_q <= `OFF_SECTOR9_RESULT) |=> bresp == RESP_SLVERR;
	endproperty
	a_reserved_write: assert property (p_reserved_write) else $error("result write not refused");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		(event_set != 2'h0) |=> (status_q & $past(event_set)) == $past(event_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("status event lost");

	property p_enable_gate;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl_enable_q && !page_start) |=> $stable(byte_addr_q);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("byte counted while disabled");

endmodule

/* nand_page_source.sv */
// Page byte source standing in for the flash on the far side of the block
`timescale 1ns/100ps
module nand_page_source (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic go,
	input  wire logic slow,
	input  wire logic flip,
	output logic      page_start,
	output logic      byte_valid,
	output logic [7:0] byte_data,
	output logic      busy
);
	logic [11:0] idx_q;
	logic        ph_q;
	logic [7:0]  mask;

	// Page content; the bench holds its own copy of this pattern
	function automatic logic [7:0] pat(input logic [11:0] i);
		return i[7:0] ^ {i[11:8], i[11:8]} ^ 8'h3C;
	endfunction

	// One corrupted bit in each of sectors 3 to 9, word {s,7}, bit s[2:0]
	// Never two per sector, so the bench may trust the location fields
	assign mask = (flip && idx_q[11:8] >= 4'h3 && idx_q[7:0] == {idx_q[11:8], 4'h7}) ? 8'h01 << idx_q[10:8] : 8'h00;

	// Framing; between bytes the data line toggles so stale data never looks valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy       <= 1'b0;
			page_start <= 1'b0;
			byte_valid <= 1'b0;
			byte_data  <= 8'h00;
			idx_q      <= 12'hA00;
			ph_q       <= 1'b0;
		end else begin
			page_start <= go && !busy;
			ph_q       <= ~ph_q;
			if (go && !busy) begin
				busy  <= 1'b1;
				idx_q <= 12'h000;
			end else if (busy && idx_q != 12'hA00 && (!slow || ph_q)) begin
				byte_valid <= 1'b1;
				byte_data  <= pat(idx_q) ^ mask;
				idx_q      <= idx_q + 12'h001;
			end else begin
				byte_valid <= 1'b0;
				byte_data  <= ~byte_data;
				if (idx_q == 12'hA00) busy <= 1'b0;
			end
		end
	end
endmodule

/* tb_top.sv */
// Self-checking bench for the sector result registers
`timescale 1ns/100ps
`include "nand_ecc_consts.svh"
module tb_top import nand_ecc_pkg::*;;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, go, slow, flip, busy;
	logic        page_start, byte_valid;
	logic [7:0]  awaddr, araddr, byte_data;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [2:0]  awprot, arprot;
	logic [1:0]  bresp, rresp;
	check_t      good [3:9];
	int          err_count, n_checks, cyc;

	nand_sector_ecc_result_regs i_nand_sector_ecc_result_regs (.aclk, .aresetn, .awvalid, .awready, .awaddr,
		.awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.arprot, .rvalid, .rready, .rdata, .rresp, .page_start, .byte_valid, .byte_data, .irq);
	nand_page_source i_nand_page_source (.aclk, .aresetn, .go, .slow, .flip, .page_start, .byte_valid,
		.byte_data, .busy);

	// Bench copy of the page pattern, kept apart from the source model
	function automatic logic [7:0] pat(input logic [11:0] i);
		return i[7:0] ^ {i[11:8], i[11:8]} ^ 8'h3C;
	endfunction

	// Check value of a clean sector: XOR of {word,bit} over every set bit
	function automatic check_t clean_chk(input logic [3:0] s);
		check_t     c;
		logic [7:0] d;
		c = 11'h000;
		for (int w = 0; w < 256; w++) begin
			d = pat({s, w[7:0]});
			for (int b = 0; b < 8; b++)
				if (d[b]) c = c ^ {w[7:0], b[2:0]};
		end
		return c;
	endfunction

	function automatic logic [7:0] res_addr(input logic [3:0] s);
		return `OFF_SECTOR3_RESULT + {2'b00, s - `SECTOR_FIRST, 2'b00};
	endfunction

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input resp_t got, input resp_t exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t flag got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Write one word; address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output resp_t r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output resp_t r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input resp_t er);
		logic [31:0] d;
		resp_t       r;
		axi_rd(a, d, r);
		chk_data(d, e);
		chk_resp(r, er);
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input resp_t er);
		resp_t r;
		axi_wr(a, d, r);
		chk_resp(r, er);
	endtask

	// Stream one page through the source model and wait for its end
	task automatic run_page(input logic sl, input logic fl);
		slow <= sl;
		flip <= fl;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (busy) @(posedge aclk);
		@(posedge aclk);
	endtask

	// Results read zero after reset; they refuse writes; a hole answers with an error
	task automatic t_reset_values();
		for (int s = 3; s <= 9; s++)
			rd_chk(res_addr(s[3:0]), 32'h0000_0000, RESP_OKAY);
		wr_chk(`OFF_SECTOR5_RESULT, 32'hFFFF_FFFF, RESP_SLVERR);
		rd_chk(`OFF_SECTOR5_RESULT, 32'h0000_0000, RESP_OKAY);
		rd_chk(8'h3C, 32'h0000_0000, RESP_SLVERR);
		chk_flag(irq, 1'b0);
	endtask

	// Clean page: check values per sector, then page-done interrupt masked, enabled, cleared
	task automatic t_clean_page();
		run_page(1'b0, 1'b0);
		for (int s = 3; s <= 9; s++) begin
			good[s] = clean_chk(s[3:0]);
			rd_chk(res_addr(s[3:0]), {9'h000, good[s], 12'h000}, RESP_OKAY);
		end
		rd_chk(`OFF_ECC_STATUS, 32'h0000_0001, RESP_OKAY);
		chk_flag(irq, 1'b0);
		wr_chk(`OFF_ECC_MASK, 32'h0000_0001, RESP_OKAY);
		@(posedge aclk);
		chk_flag(irq, 1'b1);
		wr_chk(`OFF_ECC_STATUS, 32'h0000_0001, RESP_OKAY);
		@(posedge aclk);
		chk_flag(irq, 1'b0);
	endtask

	// Stalling source, one bad bit per sector; stored check value handed back as software would
	task automatic t_single_error();
		check_t loc;
		run_page(1'b1, 1'b1);
		for (int s = 3; s <= 9; s++) begin
			loc = {s[3:0], 4'h7, s[2:0]};
			rd_chk(res_addr(s[3:0]), {9'h000, good[s] ^ loc, 12'h000}, RESP_OKAY);
			wr_chk(`OFF_ECC_EXPECT, {12'h000, s[3:0], 5'h00, good[s]}, RESP_OKAY);
			rd_chk(res_addr(s[3:0]), {9'h000, good[s] ^ loc, 1'b0, loc}, RESP_OKAY);
		end
		rd_chk(`OFF_ECC_STATUS, 32'h0000_0003, RESP_OKAY);
		chk_flag(irq, 1'b1);
		wr_chk(`OFF_ECC_STATUS, 32'h0000_0003, RESP_OKAY);
	endtask

	// Clear strobe empties the results; a disabled unit ignores a whole page
	task automatic t_control();
		wr_chk(`OFF_ECC_CTRL, 32'h0000_0002, RESP_OKAY);
		rd_chk(`OFF_ECC_CTRL, 32'h0000_0000, RESP_OKAY);
		rd_chk(res_addr(4'h5), 32'h0000_0000, RESP_OKAY);
		run_page(1'b0, 1'b0);
		rd_chk(res_addr(4'h3), 32'h0000_0000, RESP_OKAY);
		rd_chk(`OFF_ECC_STATUS, 32'h0000_0000, RESP_OKAY);
		rd_chk(`OFF_ECC_EXPECT, 32'h0000_0000, RESP_OKAY);
		wr_chk(`OFF_ECC_CTRL, 32'h0000_0001, RESP_OKAY);
		rd_chk(`OFF_ECC_CTRL, 32'h0000_0001, RESP_OKAY);
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// A hung handshake ends the run as a mismatch; the three pages need about 11000 cycles
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go, slow, flip} = 9'h000;
		{awaddr, araddr, wdata} = 48'h0;
		{awprot, arprot} = 6'h00;
		wstrb = 4'hF;
		{err_count, n_checks, cyc} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset_values();
		t_clean_page();
		t_single_error();
		t_control();
		report_and_stop();
	end
endmodule
